// [wwd_pkg.sv]
`default_nettype none
package wwd_pkg;

   localparam int          DATA_W         = 32;
   localparam int          CNT_W          = 16;
   localparam int          BYTE_W         = 8;
   localparam int          PRE_W          = 7;
   localparam int          PW_W           = 6;

   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_RELOAD     = 8'h04;
   localparam logic [7:0]  OFS_WINDOW     = 8'h08;
   localparam logic [7:0]  OFS_SERVICE    = 8'h0C;
   localparam logic [7:0]  OFS_COUNT      = 8'h10;
   localparam logic [7:0]  OFS_STATUS     = 8'h14;
   localparam logic [7:0]  OFS_MASK       = 8'h18;

   localparam int          CTRL_DIV_BIT   = 0;
   localparam int          CTRL_WEN_BIT   = 1;
   localparam int          CTRL_RUN_BIT   = 2;
   localparam logic [2:0]  CTRL_RESET     = 3'h0;
   localparam logic [7:0]  RELOAD_RESET   = 8'h00;
   localparam logic [7:0]  WINDOW_RESET   = 8'h00;

   localparam int          ST_TIMEOUT_BIT = 0;
   localparam int          ST_INVALID_BIT = 1;
   localparam int          ST_PWDONE_BIT  = 2;
   localparam int          ST_PWACT_BIT   = 8;
   localparam int          EV_W           = 3;
   localparam logic [2:0]  EV_RESET       = 3'h0;

   localparam logic [6:0]  PRE_LIM_FAST   = 7'h01;
   localparam logic [6:0]  PRE_LIM_SLOW   = 7'h7F;
   localparam logic [5:0]  PREWARN_COUNT  = 6'h30;
   localparam logic [15:0] CNT_MAX        = 16'hFFFF;
   localparam logic [7:0]  LOW_BYTE_ZERO  = 8'h00;

   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

   typedef enum logic [1:0] {WWD_RUN, WWD_PREWARN, WWD_RESET} wwd_state_t;

endpackage
`default_nettype wire

// [wwd_tick_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface wwd_tick_if;
   logic div_sel;
   logic hold;
   logic tick;
   modport ctl (output div_sel, output hold, input tick);
   modport pre (input div_sel, input hold, output tick);
endinterface
`default_nettype wire

// [wwd_prescaler.sv]
`timescale 1ns/1ns
`default_nettype none
module wwd_prescaler
   import wwd_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   wwd_tick_if.pre   tif
);

   logic [PRE_W-1:0] div_cnt;
   logic [PRE_W-1:0] limit;

   assign limit = tif.div_sel ? PRE_LIM_SLOW : PRE_LIM_FAST;

   // The count is held, not cleared, in debug so a resumed run keeps its phase.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         div_cnt <= '0;
         tif.tick <= 1'b0;
      end
      else if (tif.hold)
      begin
         tif.tick <= 1'b0;
      end
      else if (div_cnt >= limit)
      begin
         div_cnt <= '0;
         tif.tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
         tif.tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// [wwd_top.sv]
// Function
// - Supervision counter is 16 bits, a high and a low byte cascaded.
// - Counter steps at peripheral clock divided by 2 or 128 per divider select.
// - Each valid service access in the run state loads the high byte from the reload high byte.
// - Each valid service access in the run state clears the low byte to zero.
// - After service the counter keeps counting up from the reloaded value.
// - Overflow without service sets timeout flag, raises NMI, enters prewarning.
// - Prewarning lasts 0x30 count ticks, then reset request is asserted.
// - A refresh inside the window enters prewarning without timeout flag.
// - Forbidden window spans 0x0000 up to window bound concatenated with 0x00.
// - Window bound above reload value shortens the effective service period.
// - In debug mode counting is suspended; a valid service access still reloads the counter.
`timescale 1ns/1ns
`default_nettype none
module wwd_top
   import wwd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic              debug_mode,
   output logic                   nmi,
   output logic                   irq,
   output logic                   reset_request
);

   wwd_tick_if tif ();

   logic [2:0]        ctrl;
   logic [7:0]        reload_high_byte;
   logic [7:0]        window_bound;
   logic [EV_W-1:0]   status;
   logic [EV_W-1:0]   mask;
   logic [15:0]       supervision_counter;
   logic [PW_W-1:0]   prewarn_cnt;
   wwd_state_t        state;
   wwd_state_t        next_state;

   logic              wr_pend;
   logic [7:0]        wr_addr;
   logic              addr_ok;
   logic              wr_now;
   logic [31:0]       next_rdata;
   logic              service;
   logic              invalid_refresh;
   logic              overflow;
   logic              prewarn_done;
   logic [EV_W-1:0]   events;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // A set arriving with a write-one-to-clear survives the clear.
   function automatic logic [EV_W-1:0] sticky(input logic [EV_W-1:0] cur,
                                               input logic [EV_W-1:0] clr,
                                               input logic [EV_W-1:0] set);
      sticky = (cur & ~clr) | set;
   endfunction

   function automatic logic next_nmi(input logic [EV_W-1:0] st, input logic [EV_W-1:0] ev);
      next_nmi = st[ST_TIMEOUT_BIT] | ev[ST_TIMEOUT_BIT];
   endfunction

   wwd_prescaler u_pre
   (
      .clk   (clk),
      .rst_n (rst_n),
      .tif   (tif)
   );

   assign tif.div_sel = ctrl[CTRL_DIV_BIT];
   assign tif.hold    = debug_mode | ~ctrl[CTRL_RUN_BIT];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   assign wr_now    = wr_pend;

   // Address phase is captured; write data arrives one cycle later.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= addr_ok & hwrite;
         wr_addr <= {haddr[7:2], 2'b00};
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (hit({haddr[7:2], 2'b00}, OFS_CTRL))
      begin
         next_rdata[2:0] = ctrl;
      end
      else if (hit({haddr[7:2], 2'b00}, OFS_RELOAD))
      begin
         next_rdata[7:0] = reload_high_byte;
      end
      else if (hit({haddr[7:2], 2'b00}, OFS_WINDOW))
      begin
         next_rdata[7:0] = window_bound;
      end
      else if (hit({haddr[7:2], 2'b00}, OFS_COUNT))
      begin
         next_rdata[15:0] = supervision_counter;
      end
      else if (hit({haddr[7:2], 2'b00}, OFS_STATUS))
      begin
         next_rdata[EV_W-1:0]    = status;
         next_rdata[ST_PWACT_BIT] = (state != WWD_RUN);
      end
      else if (hit({haddr[7:2], 2'b00}, OFS_MASK))
      begin
         next_rdata[EV_W-1:0] = mask;
      end
      else
      begin
         next_rdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (addr_ok & ~hwrite)
      begin
         hrdata <= next_rdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl             <= CTRL_RESET;
         reload_high_byte <= RELOAD_RESET;
         window_bound     <= WINDOW_RESET;
         mask             <= EV_RESET;
      end
      else if (wr_now)
      begin
         if (hit(wr_addr, OFS_CTRL))
         begin
            ctrl <= hwdata[2:0];
         end
         else if (hit(wr_addr, OFS_RELOAD))
         begin
            reload_high_byte <= hwdata[7:0];
         end
         else if (hit(wr_addr, OFS_WINDOW))
         begin
            window_bound <= hwdata[7:0];
         end
         else if (hit(wr_addr, OFS_MASK))
         begin
            mask <= hwdata[EV_W-1:0];
         end
      end
   end

   // A write to the service word is the refresh; its data are ignored.
   assign service = wr_now & hit(wr_addr, OFS_SERVICE) & (state == WWD_RUN);

   // Window end is exclusive, so a bound of zero disables the check.
   assign invalid_refresh = service & ctrl[CTRL_WEN_BIT]
                          & (supervision_counter < {window_bound, LOW_BYTE_ZERO});

   assign overflow = (state == WWD_RUN) & tif.tick & ~service
                   & (supervision_counter == CNT_MAX);

   assign prewarn_done = (state == WWD_PREWARN) & tif.tick
                       & (prewarn_cnt == PREWARN_COUNT - 6'h01);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         supervision_counter <= 16'h0000;
      end
      else if (service & ~invalid_refresh)
      begin
         supervision_counter <= {reload_high_byte, LOW_BYTE_ZERO};
      end
      else if (tif.tick & (state == WWD_RUN))
      begin
         supervision_counter <= supervision_counter + 16'h0001;
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         WWD_RUN:
         begin
            if (overflow | invalid_refresh)
            begin
               next_state = WWD_PREWARN;
            end
         end
         WWD_PREWARN:
         begin
            if (prewarn_done)
            begin
               next_state = WWD_RESET;
            end
         end
         WWD_RESET:
         begin
            next_state = WWD_RESET;
         end
         default:
         begin
            next_state = WWD_RUN;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= WWD_RUN;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Prewarning counts watchdog ticks, so debug mode stretches it too.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         prewarn_cnt <= '0;
      end
      else if (state != WWD_PREWARN)
      begin
         prewarn_cnt <= '0;
      end
      else if (tif.tick)
      begin
         prewarn_cnt <= prewarn_cnt + 6'h01;
      end
   end

   always_comb
   begin
      events                 = EV_RESET;
      events[ST_TIMEOUT_BIT] = overflow;
      events[ST_INVALID_BIT] = invalid_refresh;
      events[ST_PWDONE_BIT]  = prewarn_done;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status <= EV_RESET;
      end
      else
      begin
         status <= sticky(status, (wr_now & hit(wr_addr, OFS_STATUS)) ? hwdata[EV_W-1:0] : EV_RESET, events);
      end
   end

   // The NMI follows the timeout flag and cannot be masked.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         nmi           <= 1'b0;
         irq           <= 1'b0;
         reset_request <= 1'b0;
      end
      else
      begin
         nmi           <= next_nmi(status, events);
         irq           <= |(sticky(status, EV_RESET, events) & mask);
         reset_request <= (next_state == WWD_RESET);
      end
   end

endmodule
`default_nettype wire

// [wwd_top_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module wwd_top_props
   import wwd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   input  wire logic        hresp,
   input  wire logic        debug_mode,
   input  wire logic        nmi,
   input  wire logic        reset_request
);
   logic        rd_go;
   logic        st_wr;
   logic        st_clr;
   logic [15:0] pw_cnt;

   assign rd_go  = hsel && hready && htrans[1] && !hwrite;
   assign st_clr = st_wr && hwdata[ST_TIMEOUT_BIT];

   always_ff @(posedge clk)
   begin
      st_wr <= rst_n && hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFS_STATUS;
   end

   // Prewarning time is counted only while debug is off, since debug legally stretches it.
   always_ff @(posedge clk)
   begin
      if (!rst_n || !nmi)
         pw_cnt <= 16'h0;
      else if (!reset_request && !debug_mode)
         pw_cnt <= pw_cnt + 16'h1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_bad_read;
      rd_go && haddr[7:2] > 6'h06;
   endsequence

   sequence s_quiet_prewarn;
      !reset_request [*8];
   endsequence

   a_rst_sticky: assert property (reset_request |=> reset_request) else $error("reset request dropped");
   a_prewarn_first: assert property ($rose(nmi) |-> s_quiet_prewarn) else $error("reset without prewarning");
   a_prewarn_min: assert property ($rose(reset_request) && nmi |-> pw_cnt >= 16'd90)
      else $error("short prewarn");
   a_prewarn_max: assert property (pw_cnt <= 16'd6150) else $error("prewarning too long");
   a_debug_hold: assert property (debug_mode [*4] |-> !$rose(nmi) && !$rose(reset_request))
      else $error("ran in debug");
   a_nmi_sticky: assert property (nmi && !st_clr && !$past(st_clr) |=> nmi) else $error("nmi dropped");
   a_count_width: assert property (hrdata[31:16] == 16'h0) else $error("upper read bits set");
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response on bus");
   a_unmapped_zero: assert property (s_bad_read |=> hrdata == 32'h0) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!rd_go |=> $stable(hrdata)) else $error("read data changed");
endmodule
`default_nettype wire

// [windowed_watchdog_timer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
   begin \
      n_tests++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module windowed_watchdog_timer_tb
   import wwd_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        debug_mode;
   logic        nmi;
   logic        irq;
   logic        reset_request;
   logic [31:0] rdat;
   logic [7:0]  ofs [7] = '{OFS_CTRL, OFS_RELOAD, OFS_WINDOW, OFS_COUNT, OFS_STATUS, OFS_MASK, 8'h1C};
   int          failures = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          t0;
   int          pf;

   wwd_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .debug_mode(debug_mode), .nmi(nmi), .irq(irq), .reset_request(reset_request));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Every call starts just after a rising edge and ends on one.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      `CHK(rdat, e)
   endtask

   // Bounded wait so a dead output cannot hang the run before the watchdog.
   task automatic wait_hi(input logic rr);
      int n;
      n = 0;
      while ((rr ? reset_request : nmi) !== 1'b1 && n < 40000)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   initial
   begin
      // The slow divider run needs about 40000 cycles; this leaves half again as margin.
      #1200000;
      failures++;
      end_sim();
   end

   initial
   begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      debug_mode = 1'b0;
      for (int dv = 0; dv < 2; dv++)
      begin
         pf = 1 << (1 + 6 * dv);
         do_reset();
         debug_mode <= 1'b1;
         foreach (ofs[i]) rdc(ofs[i], 32'h0);
         wr(OFS_RELOAD, 32'hFF);
         wr(OFS_CTRL, 32'h4 | dv);
         wr(OFS_SERVICE, 32'h0);
         rdc(OFS_COUNT, 32'hFF00);
         repeat (20) @(posedge clk);
         rdc(OFS_COUNT, 32'hFF00);
         debug_mode <= 1'b0;
         t0 = cyc;
         wait_hi(1'b0);
         `CHK(cyc - t0 >= pf * 255 && cyc - t0 <= pf * 257 + 4, 1'b1)
         t0 = cyc;
         rdc(OFS_STATUS, 32'h101);
         `CHK(irq, 1'b0)
         wr(OFS_SERVICE, 32'h0);
         rdc(OFS_COUNT, 32'h0);
         wr(OFS_MASK, 32'h1);
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b1)
         wait_hi(1'b1);
         `CHK(cyc - t0 >= pf * 48 - 3 && cyc - t0 <= pf * 48 + 3, 1'b1)
         rdc(OFS_STATUS, 32'h105);
         wr(OFS_STATUS, 32'h7);
         repeat (2) @(posedge clk);
         `CHK({nmi, irq, reset_request}, 3'b001)
         $display("timeout test with divider %0d done", dv);
      end
      do_reset();
      debug_mode <= 1'b1;
      wr(OFS_CTRL, 32'h4);
      wr(OFS_RELOAD, 32'h80);
      wr(OFS_WINDOW, 32'h80);
      wr(OFS_SERVICE, 32'h0);
      wr(OFS_CTRL, 32'h6);
      wr(OFS_SERVICE, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      rdc(OFS_COUNT, 32'h8000);
      wr(OFS_CTRL, 32'h4);
      wr(OFS_RELOAD, 32'h7F);
      wr(OFS_SERVICE, 32'h0);
      wr(OFS_SERVICE, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      rdc(OFS_COUNT, 32'h7F00);
      wr(OFS_MASK, 32'h2);
      wr(OFS_CTRL, 32'h6);
      wr(OFS_SERVICE, 32'h0);
      rdc(OFS_STATUS, 32'h102);
      `CHK({nmi, irq}, 2'b01)
      // Longer than a whole prewarning at the fast rate, so a leak through debug shows.
      repeat (120) @(posedge clk);
      `CHK(reset_request, 1'b0)
      debug_mode <= 1'b0;
      t0 = cyc;
      wait_hi(1'b1);
      `CHK(cyc - t0 >= 93 && cyc - t0 <= 100, 1'b1)
      $display("window test done");
      end_sim();
   end
endmodule

bind wwd_top wwd_top_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .debug_mode(debug_mode), .nmi(nmi),
   .hresp(hresp), .reset_request(reset_request));
`default_nettype wire
